// ==== logic/sacp_defines.vh ====
/*
  Constants of the stereo converter serial output and control port: control word layout,
  register addresses, field positions, format and width codes, and the bit clock timing.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef SACP_DEFINES_VH
`define SACP_DEFINES_VH

// ----------------------------------------------------------------
// Control word layout
// ----------------------------------------------------------------
`define SACP_WORD_BITS        16
`define SACP_ADDR_MSB         15
`define SACP_ADDR_LSB         12
`define SACP_RW_BIT           11
`define SACP_RW_READ          1'b1
`define SACP_DATA_MSB         9
`define SACP_PEAK_BITS        6

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SACP_ADDR_FRONTEND    4'h0
`define SACP_ADDR_FORMAT      4'h1
`define SACP_ADDR_CLOCK_MUX   4'h2
`define SACP_ADDR_LEFT_PEAK   4'h3
`define SACP_ADDR_RIGHT_PEAK  4'h4
`define SACP_REG_RESET        10'h000

// ----------------------------------------------------------------
// Frontend gain and power control fields
// ----------------------------------------------------------------
`define SACP_F0_PEAK_EN       9
`define SACP_F0_DC_BLOCK      8
`define SACP_F0_POWER_DOWN    7
`define SACP_F0_MOD_RATE      6
`define SACP_F0_LGAIN_MSB     5
`define SACP_F0_LGAIN_LSB     3
`define SACP_F0_RGAIN_MSB     2
`define SACP_F0_RGAIN_LSB     0

// ----------------------------------------------------------------
// Serial format control fields
// ----------------------------------------------------------------
`define SACP_F1_MOD_MODE      7
`define SACP_F1_FMT_MSB       6
`define SACP_F1_FMT_LSB       5
`define SACP_F1_WW_MSB        4
`define SACP_F1_WW_LSB        3
`define SACP_F1_SLAVE         2
`define SACP_F1_MUTE_R        1
`define SACP_F1_MUTE_L        0

// ----------------------------------------------------------------
// Format and width codes
// ----------------------------------------------------------------
`define SACP_FMT_I2S          2'h0
`define SACP_FMT_RJ           2'h1
`define SACP_FMT_DSP          2'h2
`define SACP_FMT_LJ           2'h3
`define SACP_WW_24            2'h0
`define SACP_WW_20            2'h1
`define SACP_WW_16            2'h2
`define SACP_LEN_24           5'h18
`define SACP_LEN_20           5'h14
`define SACP_LEN_16           5'h10
`define SACP_MASK_24          24'hffffff
`define SACP_MASK_20          24'hfffff0
`define SACP_MASK_16          24'hffff00
`define SACP_SAMPLE_MSB       5'h17
`define SACP_HALF_SLOTS       6'h20
`define SACP_SYNC_SLOT        6'h3f

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SACP_CLK_PERIOD_NS    10
`define SACP_BCLK_PERIOD_NS   160
`define SACP_BCLK_HALF_CYC    (`SACP_BCLK_PERIOD_NS / (2 * `SACP_CLK_PERIOD_NS))
`define SACP_PIN_COUNT        7

`endif

// ==== logic/sacp_pin_sync.v ====
/*
  Three-stage synchroniser for the pins that arrive from outside the system clock.
  Assumes all pins are slow compared with the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sacp_defines.vh"

module sacp_pin_sync (
  input  wire                        clk_sys_in,
  input  wire                        reset_n_in,
  input  wire                        clk_en_in,
  input  wire [`SACP_PIN_COUNT-1:0]  pin_in,
  output wire [`SACP_PIN_COUNT-1:0]  level_out
);

  // ----------------------------------------------------------------
  // Per pin stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `SACP_PIN_COUNT; i = i + 1)
    begin : g_pin
      reg stage1;
      reg stage2;
      reg stage3;
      reg level;
      always @(posedge clk_sys_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
          level  <= 1'b0;
        end
        else if (clk_en_in)
        begin
          stage1 <= pin_in[i];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3)
          begin
            level <= stage3;
          end
        end
      end
      assign level_out[i] = level;
    end
  endgenerate

endmodule // sacp_pin_sync

`default_nettype wire

// ==== logic/sacp_serial_port.v ====
/*
  Serial sample output port and serial control port of a stereo converter.
  Assumes samples arrive from the filter datapath on the system clock, while the bit clock,
  frame clock, chain input and control port pins arrive asynchronously.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sacp_defines.vh"

// How it works
// - Frame at sample rate, 64 bit clocks.
// - Output changes on bit clock falling edges.
// - Samples are 16, 20 or 24 bits.
// - I2S: MSB second period, fall is left.
// - LJ: MSB first period, rise is left.
// - RJ: LSB in last period of half.
// - DSP: one period sync, then MSB.
// - Chain select pin enables cascade operation.
// - Cascade: 64-bit register, zero padded subframes.
// - Chain input feeds from the further device.
// - Sync loads register, shifts chain input behind.
// - Cascade forces left-justified framing.
// - Host or one device drives clocks.
// - Chained control words, shared latch applies.
// - Word: address, read flag, reserved, data.
// - Decode three control, two peak registers.
// - Peak readings returned in control frame.
// - Transfers only while latch held low.
// - Control clock samples input, drives return.
// - First register holds gain and power fields.
// - Format codes: I2S, RJ, DSP, LJ.
// - Width codes: 24, 20, 16, reserved.
// - Master drives clocks, slave receives them.
module sacp_serial_port (
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  input  wire        clk_en_in,
  input  wire        frame_clk_in,
  output reg         frame_clk_out,
  output reg         frame_clk_oe_out,
  input  wire        bit_clk_in,
  output reg         bit_clk_out,
  output reg         bit_clk_oe_out,
  output reg         sample_serial_out,
  input  wire        daisy_chain_select_in,
  input  wire        chain_serial_in,
  input  wire [23:0] left_sample_in,
  input  wire [23:0] right_sample_in,
  input  wire [5:0]  left_peak_in,
  input  wire [5:0]  right_peak_in,
  input  wire        control_serial_clock_in,
  input  wire        control_latch_in,
  input  wire        control_serial_in,
  output reg         control_serial_return_out,
  output reg         control_serial_return_oe_out,
  output wire        peak_enable_out,
  output wire        dc_block_enable_out,
  output wire        power_down_out,
  output wire        modulator_rate_select_out,
  output wire [2:0]  left_gain_field_out,
  output wire [2:0]  right_gain_field_out,
  output wire        modulator_mode_out,
  output wire [9:0]  clock_input_mux_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [`SACP_PIN_COUNT-1:0] sync_lvl;
  wire                       s_frame;
  wire                       s_bclk;
  wire                       s_chain;
  wire                       s_control_serial_clock;
  wire                       s_latch;
  wire                       s_control_serial_in;
  wire                       s_daisy_chain_select;

  sacp_pin_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .pin_in     ({daisy_chain_select_in, frame_clk_in, bit_clk_in, chain_serial_in,
                  control_serial_clock_in, control_latch_in, control_serial_in}),
    .level_out  (sync_lvl)
  );

  assign {s_daisy_chain_select, s_frame, s_bclk, s_chain, s_control_serial_clock, s_latch, s_control_serial_in} = sync_lvl;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg  [9:0]  frontend_gain_power_control;
  reg  [9:0]  serial_format_control;
  reg  [9:0]  clock_input_mux_control;
  wire        slave_mode = serial_format_control[`SACP_F1_SLAVE];
  wire [1:0]  fmt_field  = serial_format_control[`SACP_F1_FMT_MSB:`SACP_F1_FMT_LSB];
  wire [1:0]  ww_field   = serial_format_control[`SACP_F1_WW_MSB:`SACP_F1_WW_LSB];
  wire [1:0]  eff_fmt    = s_daisy_chain_select ? `SACP_FMT_LJ : fmt_field;

  assign peak_enable_out           = frontend_gain_power_control[`SACP_F0_PEAK_EN];
  assign dc_block_enable_out       = frontend_gain_power_control[`SACP_F0_DC_BLOCK];
  assign power_down_out            = frontend_gain_power_control[`SACP_F0_POWER_DOWN];
  assign modulator_rate_select_out = frontend_gain_power_control[`SACP_F0_MOD_RATE];
  assign left_gain_field_out       = frontend_gain_power_control[`SACP_F0_LGAIN_MSB:`SACP_F0_LGAIN_LSB];
  assign right_gain_field_out      = frontend_gain_power_control[`SACP_F0_RGAIN_MSB:`SACP_F0_RGAIN_LSB];
  assign modulator_mode_out        = serial_format_control[`SACP_F1_MOD_MODE];
  assign clock_input_mux_out       = clock_input_mux_control;

  // ----------------------------------------------------------------
  // Word width decode
  // ----------------------------------------------------------------
  reg [4:0]  word_len;
  reg [23:0] word_mask;

  always @*
  begin
    case (ww_field)
      `SACP_WW_20:
      begin
        word_len  = `SACP_LEN_20;
        word_mask = `SACP_MASK_20;
      end
      `SACP_WW_16:
      begin
        word_len  = `SACP_LEN_16;
        word_mask = `SACP_MASK_16;
      end
      default:
      begin
        word_len  = `SACP_LEN_24;
        word_mask = `SACP_MASK_24;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bit clock events
  // ----------------------------------------------------------------
  reg  [3:0] div_cnt;
  reg        bclk_q;
  reg        s_bclk_prev;
  reg  [5:0] mcnt;
  reg        lr_prev;
  reg  [5:0] fpos;
  reg        chain_bit;
  reg [63:0] shreg;
  reg [23:0] left_hold;
  reg [23:0] right_hold;
  wire       div_wrap = (div_cnt == `SACP_BCLK_HALF_CYC - 1);
  wire       fall_evt = slave_mode ? (s_bclk_prev & ~s_bclk) : (div_wrap & bclk_q);
  wire       rise_evt = slave_mode ? (~s_bclk_prev & s_bclk) : (div_wrap & ~bclk_q);
  wire [5:0] next_mcnt = mcnt + 6'h01;

  // ----------------------------------------------------------------
  // Frame position and output bit
  // ----------------------------------------------------------------
  reg        next_lr_m;
  reg        lr_now;
  reg  [5:0] next_fpos;
  reg  [4:0] offset;
  reg  [4:0] k_idx;
  reg [23:0] cur_word;
  reg        frame_start;
  reg        muted;
  reg        next_bit;
  reg [63:0] next_shreg;

  always @*
  begin
    next_lr_m = (eff_fmt == `SACP_FMT_DSP) ? (next_mcnt == `SACP_SYNC_SLOT)
                                           : (next_mcnt[5] ^ (eff_fmt != `SACP_FMT_I2S));
    lr_now = slave_mode ? s_frame : next_lr_m;
    if (eff_fmt == `SACP_FMT_DSP)
    begin
      next_fpos = (lr_now & ~lr_prev) ? `SACP_SYNC_SLOT : fpos + 6'h01;
    end
    else if (lr_now != lr_prev)
    begin
      next_fpos = (lr_now ^ (eff_fmt == `SACP_FMT_I2S)) ? 6'h00 : `SACP_HALF_SLOTS;
    end
    else
    begin
      next_fpos = fpos + 6'h01;
    end
    offset = (eff_fmt == `SACP_FMT_I2S) ? 5'h01 : (eff_fmt == `SACP_FMT_RJ) ? 5'h00 - word_len : 5'h00;
    frame_start = (next_fpos == 6'h00) && (fpos != 6'h00);
    cur_word = next_fpos[5] ? right_hold : (frame_start ? left_sample_in : left_hold);
    muted    = serial_format_control[next_fpos[5] ? `SACP_F1_MUTE_R : `SACP_F1_MUTE_L];
    k_idx = next_fpos[4:0] - offset;
    next_bit = ((next_fpos[4:0] >= offset) && (k_idx < word_len) && !muted) ? cur_word[`SACP_SAMPLE_MSB - k_idx] : 1'b0;
    if (frame_start)
    begin
      next_shreg = {left_sample_in & word_mask & {24{~serial_format_control[`SACP_F1_MUTE_L]}}, 8'h00,
                    right_sample_in & word_mask & {24{~serial_format_control[`SACP_F1_MUTE_R]}},
                    8'h00};
    end
    else
    begin
      next_shreg = {shreg[62:0], chain_bit};
    end
  end

  // ----------------------------------------------------------------
  // Serial output engine
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      div_cnt           <= 4'h0;
      bclk_q            <= 1'b0;
      s_bclk_prev       <= 1'b0;
      mcnt              <= 6'h00;
      lr_prev           <= 1'b0;
      fpos              <= 6'h00;
      chain_bit         <= 1'b0;
      shreg             <= 64'h0000000000000000;
      left_hold         <= 24'h000000;
      right_hold        <= 24'h000000;
      sample_serial_out <= 1'b0;
      frame_clk_out     <= 1'b0;
      frame_clk_oe_out  <= 1'b0;
      bit_clk_out       <= 1'b0;
      bit_clk_oe_out    <= 1'b0;
    end
    else if (clk_en_in)
    begin
      s_bclk_prev      <= s_bclk;
      frame_clk_oe_out <= ~slave_mode;
      bit_clk_oe_out   <= ~slave_mode;
      if (div_wrap)
      begin
        div_cnt <= 4'h0;
        bclk_q  <= ~bclk_q;
      end
      else
      begin
        div_cnt <= div_cnt + 4'h1;
      end
      bit_clk_out <= div_wrap ? ~bclk_q : bclk_q;
      if (rise_evt)
      begin
        chain_bit <= s_chain;
      end
      if (fall_evt)
      begin
        mcnt    <= next_mcnt;
        lr_prev <= lr_now;
        fpos    <= next_fpos;
        if (!slave_mode)
        begin
          frame_clk_out <= next_lr_m;
        end
        if (frame_start)
        begin
          left_hold  <= left_sample_in;
          right_hold <= right_sample_in;
        end
        shreg             <= next_shreg;
        sample_serial_out <= s_daisy_chain_select ? next_shreg[63] : next_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control port
  // ----------------------------------------------------------------
  reg         s_control_serial_clock_prev;
  reg         s_latch_prev;
  reg  [15:0] csr;
  reg   [9:0] read_data;
  wire  [3:0] c_addr = csr[`SACP_ADDR_MSB:`SACP_ADDR_LSB];
  wire        latch_rise = s_latch & ~s_latch_prev;

  always @*
  begin
    case (c_addr)
      `SACP_ADDR_FORMAT:
      begin
        read_data = serial_format_control;
      end
      `SACP_ADDR_CLOCK_MUX:
      begin
        read_data = clock_input_mux_control;
      end
      `SACP_ADDR_LEFT_PEAK:
      begin
        read_data = {4'h0, left_peak_in & {`SACP_PEAK_BITS{peak_enable_out}}};
      end
      `SACP_ADDR_RIGHT_PEAK:
      begin
        read_data = {4'h0, right_peak_in & {`SACP_PEAK_BITS{peak_enable_out}}};
      end
      default:
      begin
        read_data = 10'h000;
      end
    endcase
  end

  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_control_serial_clock_prev                  <= 1'b0;
      s_latch_prev                 <= 1'b1;
      csr                          <= 16'h0000;
      control_serial_return_out    <= 1'b0;
      control_serial_return_oe_out <= 1'b0;
      frontend_gain_power_control  <= `SACP_REG_RESET;
      serial_format_control        <= `SACP_REG_RESET;
      clock_input_mux_control      <= `SACP_REG_RESET;
    end
    else if (clk_en_in)
    begin
      s_control_serial_clock_prev                  <= s_control_serial_clock;
      s_latch_prev                 <= s_latch;
      control_serial_return_oe_out <= ~s_latch;
      if (!s_latch && s_control_serial_clock && !s_control_serial_clock_prev)
      begin
        csr <= {csr[14:0], s_control_serial_in};
      end
      else if (latch_rise)
      begin
        if (csr[`SACP_RW_BIT] == `SACP_RW_READ)
        begin
          csr <= {c_addr, `SACP_RW_READ, 1'b0, read_data};
        end
        else
        begin
          case (c_addr)
            `SACP_ADDR_FRONTEND:
            begin
              frontend_gain_power_control <= csr[`SACP_DATA_MSB:0];
            end
            `SACP_ADDR_FORMAT:
            begin
              serial_format_control <= csr[`SACP_DATA_MSB:0];
            end
            `SACP_ADDR_CLOCK_MUX:
            begin
              clock_input_mux_control <= csr[`SACP_DATA_MSB:0];
            end
            default:
            begin
              clock_input_mux_control <= clock_input_mux_control;
            end
          endcase
        end
      end
      if (!s_latch && !s_control_serial_clock && s_control_serial_clock_prev)
      begin
        control_serial_return_out <= csr[15];
      end
    end
  end

endmodule // sacp_serial_port

`default_nettype wire

// ==== tb/sacp_checker.sv ====
/*
  Assertions on the serial port pins: bit clock shape, data timing and the control return.
  Assumes it is bound to the serial port module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module sacp_checker (
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic       bit_clk_out,
  input wire logic       bit_clk_oe_out,
  input wire logic       frame_clk_oe_out,
  input wire logic       sample_serial_out,
  input wire logic       daisy_chain_select_in,
  input wire logic       control_serial_clock_in,
  input wire logic       control_latch_in,
  input wire logic       control_serial_return_out,
  input wire logic       control_serial_return_oe_out,
  input wire logic [9:0] clock_input_mux_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  a_oe_pair: assert property (bit_clk_oe_out == frame_clk_oe_out)
    else $error("bit and frame clock enables differ");
  a_bclk_high: assert property (disable iff (!reset_n_in || !bit_clk_oe_out)
    $rose(bit_clk_out) |-> bit_clk_out [*8] ##1 !bit_clk_out) else $error("bit clock high phase wrong");
  a_bclk_low: assert property (disable iff (!reset_n_in || !bit_clk_oe_out)
    $fell(bit_clk_out) |-> !bit_clk_out [*8] ##1 bit_clk_out) else $error("bit clock low phase wrong");
  a_data_fall: assert property ($changed(sample_serial_out) && bit_clk_oe_out |-> !bit_clk_out)
    else $error("sample data changed while bit clock high");
  a_ret_oe_on: assert property (!control_latch_in [*8] |-> control_serial_return_oe_out)
    else $error("return not enabled while latch low");
  a_ret_oe_off: assert property (control_latch_in [*8] |-> !control_serial_return_oe_out)
    else $error("return enabled while latch high");
  a_ret_fall: assert property ($changed(control_serial_return_out) && $past(control_serial_return_oe_out, 8)
    |-> !control_serial_clock_in) else $error("return changed while control clock high");
  a_regs_latch: assert property ($changed(clock_input_mux_out) |-> control_latch_in)
    else $error("register changed while latch low");
  cover property (daisy_chain_select_in && $changed(sample_serial_out));
  cover property (!bit_clk_oe_out && $changed(sample_serial_out));
  cover property ($fell(control_serial_return_oe_out));
endmodule // sacp_checker
bind sacp_serial_port sacp_checker u_chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .bit_clk_out(bit_clk_out), .bit_clk_oe_out(bit_clk_oe_out), .frame_clk_oe_out(frame_clk_oe_out),
  .sample_serial_out(sample_serial_out), .daisy_chain_select_in(daisy_chain_select_in),
  .control_serial_clock_in(control_serial_clock_in), .control_latch_in(control_latch_in),
  .control_serial_return_out(control_serial_return_out),
  .control_serial_return_oe_out(control_serial_return_oe_out), .clock_input_mux_out(clock_input_mux_out));
`default_nettype wire

// ==== tb/sacp_host_model.sv ====
/*
  Host receive port model: rebuilds 32-bit words from the sample wire.
  Assumes the bench resolves the bit clock and frame wires from both drivers.
*/
`timescale 1ns/10ps
`default_nettype none
module sacp_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        bclk_in,
  input  wire logic        frame_in,
  input  wire logic        data_in,
  input  wire logic        left_on_fall_in,
  output var  logic [31:0] word_out,
  output var  logic        word_valid_out = 1'b0,
  output var  logic        word_left_out
);
  logic [2:0]  b, f, d;
  logic [31:0] sr;
  logic [5:0]  cnt = 6'h00;
  logic        fp = 1'b0;
  wire  [5:0]  nc = (f[1] != fp && f[1] != left_on_fall_in) ? 6'h00 : cnt + 6'h01;
  always @(posedge clk_sys_in)
  begin
    b <= {b[1:0], bclk_in};
    f <= {f[1:0], frame_in};
    d <= {d[1:0], data_in};
    word_valid_out <= 1'b0;
    if (reset_n_in && b[1] && !b[2])
    begin
      fp <= f[1];
      cnt <= nc;
      sr <= {sr[30:0], d[1]};
      if (nc[4:0] == 5'h1f)
      begin
        word_out <= {sr[30:0], d[1]};
        word_left_out <= !nc[5];
        word_valid_out <= 1'b1;
      end
    end
  end
endmodule // sacp_host_model
`default_nettype wire

// ==== tb/tb_sacp_serial_port.sv ====
/*
  Testbench of the serial port: register writes and reads, then sample frames in every format.
  Assumes the design files and the host model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sacp_defines.vh"
module tb_sacp_serial_port;
  logic clk_sys_in = 0, reset_n_in = 0, bclk = 0, fclk = 0, daisy_chain_select = 0, lfall = 0;
  logic ccl = 1, clat = 1, cdat = 0;
  logic [23:0] ls = 0, rs = 0;
  logic [5:0] lp = 0, rp = 0, bcnt = 0;
  logic [31:0] seed = 32'h9c86448f;
  logic [31:0] q[$];
  int n_errors = 0, comparisons = 0;
  logic fo, foe, bo, boe, sd, cr, croe, pe, dc, pd, mr, mm, wv, wl;
  logic [2:0] lg, rg;
  logic [9:0] cmx;
  logic [31:0] w;
  always #5 clk_sys_in = ~clk_sys_in;
  always #80 bclk = ~bclk;
  always @(negedge bclk)
  begin
    bcnt <= bcnt + 6'h01;
    fclk <= bcnt[5];
  end
  sacp_serial_port dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
    .frame_clk_in(fclk), .frame_clk_out(fo), .frame_clk_oe_out(foe), .bit_clk_in(bclk),
    .bit_clk_out(bo), .bit_clk_oe_out(boe), .sample_serial_out(sd), .daisy_chain_select_in(daisy_chain_select),
    .chain_serial_in(1'b0), .left_sample_in(ls), .right_sample_in(rs), .left_peak_in(lp),
    .right_peak_in(rp), .control_serial_clock_in(ccl), .control_latch_in(clat),
    .control_serial_in(cdat), .control_serial_return_out(cr), .control_serial_return_oe_out(croe),
    .peak_enable_out(pe), .dc_block_enable_out(dc), .power_down_out(pd), .modulator_rate_select_out(mr),
    .left_gain_field_out(lg), .right_gain_field_out(rg), .modulator_mode_out(mm),
    .clock_input_mux_out(cmx));
  sacp_host_model host (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .bclk_in(boe ? bo : bclk),
    .frame_in(foe ? fo : fclk), .data_in(sd), .left_on_fall_in(lfall), .word_out(w),
    .word_valid_out(wv), .word_left_out(wl));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] expw(input logic [23:0] s, input logic [1:0] f, input logic [4:0] n);
    logic [31:0] v;
    v = {(s >> (5'h18 - n)) << (5'h18 - n), 8'h00};
    if (f == `SACP_FMT_I2S)
      v = v >> 1;
    if (f == `SACP_FMT_RJ)
      v = v >> (6'h20 - n);
    return v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ctl(input logic [15:0] wd, output logic [15:0] rd);
    clat <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    for (int i = 15; i >= 0; i--)
    begin
      ccl <= 1'b0;
      cdat <= wd[i];
      repeat (10) @(posedge clk_sys_in);
      rd[i] = cr;
      ccl <= 1'b1;
      repeat (10) @(posedge clk_sys_in);
    end
    clat <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [9:0] d);
    logic [15:0] r;
    ctl({a, 2'b10, 10'h000}, r);
    ctl({4'hf, 2'b10, 10'h000}, r);
    chk({16'h0, r}, {16'h0, a, 2'b10, d});
  endtask
  task automatic frames(input logic [1:0] fm, input logic [1:0] ww, input logic sl, input logic [1:0] mu);
    logic [15:0] r;
    logic [4:0] n;
    logic [1:0] ef;
    seed = xs(seed);
    ls <= seed[23:0];
    seed = xs(seed);
    rs <= seed[23:0];
    ctl({6'h04, 3'b000, fm, ww, sl, mu}, r);
    if (sl)
      rdchk(4'h1, {3'b000, fm, ww, sl, mu});
    ef = daisy_chain_select ? `SACP_FMT_LJ : fm;
    n = (ww == `SACP_WW_20) ? `SACP_LEN_20 : (ww == `SACP_WW_16) ? `SACP_LEN_16 : `SACP_LEN_24;
    lfall <= !ef[0];
    repeat (900) @(posedge clk_sys_in);
    q.push_back(mu[0] ? 32'h0 : expw(ls, ef, n));
    q.push_back(mu[1] ? 32'h0 : expw(rs, ef, n));
    repeat (1700) @(posedge clk_sys_in);
    if (q.size() != 0)
    begin
      n_errors++;
      $display("mismatch at %0t: missing words", $time);
      q.delete();
    end
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_in)
    if (wv && q.size() > 0 && (q.size() == 1 || wl))
      chk(w, q.pop_front());
  initial
  begin
    logic [15:0] r;
    logic [9:0] v;
    repeat (6) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk({21'h0, mm, pe, dc, pd, mr, lg, rg}, 32'h0);
    chk({22'h0, cmx}, 32'h0);
    seed = xs(seed);
    v = seed[9:0];
    ctl({6'h00, v}, r);
    chk({22'h0, pe, dc, pd, mr, lg, rg}, {22'h0, v});
    for (int a = 3; a < 6; a = a + 2)
    begin
      ctl({a[3:0], 2'b00, ~v}, r);
      chk({22'h0, pe, dc, pd, mr, lg, rg}, {22'h0, v});
    end
    rdchk(4'h0, 10'h000);
    ctl({6'h08, ~v}, r);
    chk({22'h0, cmx}, {22'h0, ~v});
    rdchk(4'h2, ~v);
    lp <= seed[15:10];
    rp <= seed[21:16];
    ctl({6'h00, 10'h200}, r);
    rdchk(4'h3, {4'h0, lp});
    rdchk(4'h4, {4'h0, rp});
    ctl({6'h00, 10'h000}, r);
    rdchk(4'h3, 10'h000);
    for (int f = 0; f < 4; f++)
      for (int k = 0; k < 4; k++)
        frames(f[1:0], k[1:0], 1'b0, 2'b00);
    frames(`SACP_FMT_RJ, `SACP_WW_16, 1'b0, 2'b01);
    daisy_chain_select <= 1'b1;
    for (int k = 0; k < 3; k++)
      frames(`SACP_FMT_DSP, k[1:0], 1'b0, 2'b00);
    daisy_chain_select <= 1'b0;
    frames(`SACP_FMT_LJ, `SACP_WW_20, 1'b1, 2'b00);
    results();
  end
  initial
  begin
    repeat (90000) @(posedge clk_sys_in);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule // tb_sacp_serial_port
`default_nettype wire
